/* File: core/vssa_alu.sv */
// Purpose: packed shift and Q15/Q31 subtract execute unit
// Assumes: pipeline latches results one cycle after issue
// Notes: results and flag-set request appear together, registered
//
// Contract
// - immediate byte shift, four lanes, zero fill
// - halfword shift count from low four bits
// - halfword lanes shifted independently with zero fill
// - variable byte shift uses low three bits
// - no operand-dependent traps; flag only
// - disabled or unimplemented raises exception instead
// - Q15 lanes subtracted independently in place
// - wrap subtract keeps low sixteen bits
// - saturating lane clamps to 7fff or 8000
// - halfword overflow requests control bit 20
// - Q31 subtract saturates via 33-bit difference
// - word overflow requests control bit 20
`timescale 1ns/100ps
`default_nettype none
module vssa_alu
   import vssa_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // issue
   input wire logic issue_valid,
   input wire vssa_op_type op,
   input wire logic dsp_enabled,
   input wire logic [2:0] shift_amount,
   input wire logic [31:0] first_source_reg,
   input wire logic [31:0] second_source_reg,
   // result
   output logic result_valid,
   output logic [31:0] result,
   output logic flag_set,
   output logic [31:0] flag_set_mask,
   output logic dsp_disabled_exc,
   output logic reserved_instr_exc
);
   // ==========================================================
   // shifters
   logic [3:0] half_cnt;
   logic [2:0] var_byte_cnt;
   logic [2:0] byte_cnt;
   logic [31:0] byte_shift;
   logic [31:0] half_shift;
   assign half_cnt = first_source_reg[VSSA_HALF_CNT_W-1:0];
   assign var_byte_cnt = first_source_reg[VSSA_BYTE_CNT_W-1:0];
   assign byte_cnt = (op == VSSA_OP_QB_SHR_VAR) ? var_byte_cnt : shift_amount;
   genvar gi;
   // byte lanes shift independently; a count of zero passes the lane through
   generate
      for (gi = 0; gi < VSSA_DATA_W / VSSA_BYTE_W; gi++) begin : g_byte
         assign byte_shift[gi*VSSA_BYTE_W +: VSSA_BYTE_W] =
            second_source_reg[gi*VSSA_BYTE_W +: VSSA_BYTE_W] >> byte_cnt;
      end
      for (gi = 0; gi < VSSA_DATA_W / VSSA_HALF_W; gi++) begin : g_half
         assign half_shift[gi*VSSA_HALF_W +: VSSA_HALF_W] =
            second_source_reg[gi*VSSA_HALF_W +: VSSA_HALF_W] >> half_cnt;
      end
   endgenerate
   // shift checks watch one lane each; all lanes come from the same loop body
   a_byte_imm_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_QB_SHR_IMM)
      |=> result[31:24] == ($past(second_source_reg[31:24]) >> $past(shift_amount)))
      else $error("byte shift wrong");
   a_half_var_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_PH_SHR_VAR)
      |=> result[15:0] == ($past(second_source_reg[15:0]) >> $past(first_source_reg[3:0])))
      else $error("half shift wrong");
   a_byte_var_shift: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_QB_SHR_VAR)
      |=> result[7:0] == ($past(second_source_reg[7:0]) >> $past(first_source_reg[2:0])))
      else $error("byte var shift wrong");
   // ==========================================================
   // subtractors
   logic [15:0] lane_hi;
   logic [15:0] lane_lo;
   logic ovf_hi;
   logic ovf_lo;
   logic lane_sat;
   assign lane_sat = (op == VSSA_OP_PH_SUB_SAT);
   // upper lane lands in 31..16, lower in 15..0
   vssa_q15_lane u_hi (
      .a(first_source_reg[31:16]),
      .b(second_source_reg[31:16]),
      .sat(lane_sat),
      .result(lane_hi),
      .ovf(ovf_hi)
   );
   vssa_q15_lane u_lo (
      .a(first_source_reg[15:0]),
      .b(second_source_reg[15:0]),
      .sat(lane_sat),
      .result(lane_lo),
      .ovf(ovf_lo)
   );
   logic [32:0] wdiff;
   logic wovf;
   logic [31:0] wres;
   always_comb begin
      wdiff = {first_source_reg[31], first_source_reg}
            - {second_source_reg[31], second_source_reg};
      wovf = wdiff[32] ^ wdiff[31];
      wres = wdiff[31:0];
      if (wovf) begin
         wres = wdiff[32] ? VSSA_W_MIN : VSSA_W_MAX;
      end
   end
   // subtract checks: clamp values and flag requests, per lane and per word
   a_half_sat_clamp: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_PH_SUB_SAT && ovf_lo)
      |=> flag_set && (result[15:0] == 16'h7fff || result[15:0] == 16'h8000))
      else $error("half clamp wrong");
   a_word_sat_clamp: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_W_SUB_SAT && wovf && !wdiff[32])
      |=> flag_set && result == 32'h7fffffff)
      else $error("word clamp wrong");
   a_word_neg_clamp: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_W_SUB_SAT && wovf && wdiff[32])
      |=> flag_set && result == 32'h80000000)
      else $error("word low clamp wrong");
   a_wrap_low_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_PH_SUB_WRAP)
      |=> result[31:16] == 16'($past(first_source_reg[31:16]) - $past(second_source_reg[31:16])))
      else $error("wrap result wrong");
   a_half_ovf_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_PH_SUB_WRAP && ovf_hi) |=> flag_set)
      else $error("wrap overflow not flagged");
   a_word_no_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && op == VSSA_OP_W_SUB_SAT
      && first_source_reg[31] == second_source_reg[31]) |=> !flag_set)
      else $error("flag without overflow");
   // ==========================================================
   // result select and registers
   logic next_result_valid;
   logic [31:0] next_result;
   logic next_flag_set;
   logic next_dis_exc;
   logic next_ri_exc;
   logic [31:0] next_flag_set_mask;
   // overflow never traps; it only raises the flag request
   always_comb begin
      next_result_valid = 1'b0;
      next_result = VSSA_ZERO;
      next_flag_set = 1'b0;
      next_dis_exc = 1'b0;
      next_ri_exc = 1'b0;
      next_flag_set_mask = VSSA_ZERO;
      if (issue_valid) begin
         if (!dsp_enabled) begin
            next_dis_exc = 1'b1;
         end else begin
            next_result_valid = 1'b1;
            case (op)
               VSSA_OP_QB_SHR_IMM: next_result = byte_shift;
               VSSA_OP_QB_SHR_VAR: next_result = byte_shift;
               VSSA_OP_PH_SHR_VAR: next_result = half_shift;
               VSSA_OP_PH_SUB_WRAP, VSSA_OP_PH_SUB_SAT: begin
                  next_result = {lane_hi, lane_lo};
                  next_flag_set = ovf_hi | ovf_lo;
               end
               VSSA_OP_W_SUB_SAT: begin
                  next_result = wres;
                  next_flag_set = wovf;
               end
               default: begin
                  next_result_valid = 1'b0;
                  next_ri_exc = 1'b1;
               end
            endcase
         end
      end
      // only bit 20 is ever requested; the host ors it in and never clears
      next_flag_set_mask[VSSA_FLAG_BIT] = next_flag_set;
   end
   // one stage: value and flag request leave on the same edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         result_valid <= 1'b0;
         result <= VSSA_ZERO;
         flag_set <= 1'b0;
         flag_set_mask <= VSSA_ZERO;
         dsp_disabled_exc <= 1'b0;
         reserved_instr_exc <= 1'b0;
      end else begin
         result_valid <= next_result_valid;
         result <= next_result;
         flag_set <= next_flag_set;
         flag_set_mask <= next_flag_set_mask;
         dsp_disabled_exc <= next_dis_exc;
         reserved_instr_exc <= next_ri_exc;
      end
   end
   // ==========================================================
   // checks
   // flag and exception checks on the registered outputs
   a_flag_only_sub: assert property (@(posedge clk_sys) disable iff (!rst_n)
      flag_set |-> $past(op) inside {VSSA_OP_PH_SUB_WRAP, VSSA_OP_PH_SUB_SAT,
      VSSA_OP_W_SUB_SAT})
      else $error("flag raised by non-subtract");
   a_flag_mask_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      flag_set_mask == (flag_set ? 32'h00100000 : 32'h0))
      else $error("flag mask wrong");
   a_dis_no_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && !dsp_enabled) |=> (dsp_disabled_exc && !result_valid && !flag_set))
      else $error("disabled op executed");
   a_resv_no_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (issue_valid && dsp_enabled && !(op inside {VSSA_OP_QB_SHR_IMM, VSSA_OP_QB_SHR_VAR,
      VSSA_OP_PH_SHR_VAR, VSSA_OP_PH_SUB_WRAP, VSSA_OP_PH_SUB_SAT, VSSA_OP_W_SUB_SAT}))
      |=> (reserved_instr_exc && !result_valid && !flag_set))
      else $error("reserved op executed");
   a_result_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      result_valid |-> ($past(issue_valid) && $past(dsp_enabled)))
      else $error("result without issue");
   a_flag_with_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
      flag_set |-> result_valid)
      else $error("flag apart from result");
   c_word_ovf: cover property (@(posedge clk_sys) disable iff (!rst_n)
      issue_valid && dsp_enabled && op == VSSA_OP_W_SUB_SAT && wovf);
   c_half_ovf: cover property (@(posedge clk_sys) disable iff (!rst_n)
      issue_valid && dsp_enabled && op == VSSA_OP_PH_SUB_SAT && ovf_hi);
   c_disabled: cover property (@(posedge clk_sys) disable iff (!rst_n) dsp_disabled_exc);
   c_reserved: cover property (@(posedge clk_sys) disable iff (!rst_n) reserved_instr_exc);
endmodule
`default_nettype wire

/* File: core/vssa_pkg.sv */
// Purpose: shared constants and types for the vector shift/subtract execute unit
// Assumes: 32-bit data path, one instruction per cycle
// Notes: opcode encoding is local to this unit
`default_nettype none
package vssa_pkg;
   // ==========================================================
   // operation select
   typedef enum logic [2:0] {
      VSSA_OP_NONE = 3'h0,
      VSSA_OP_QB_SHR_IMM = 3'h1,
      VSSA_OP_PH_SHR_VAR = 3'h3,
      VSSA_OP_QB_SHR_VAR = 3'h2,
      VSSA_OP_PH_SUB_WRAP = 3'h6,
      VSSA_OP_PH_SUB_SAT = 3'h7,
      VSSA_OP_W_SUB_SAT = 3'h5
   } vssa_op_type;
   // ==========================================================
   // data layout
   localparam int VSSA_DATA_W = 32;
   localparam int VSSA_HALF_W = 16;
   localparam int VSSA_BYTE_W = 8;
   localparam int VSSA_HALF_CNT_W = 4;
   localparam int VSSA_BYTE_CNT_W = 3;
   localparam int VSSA_FLAG_BIT = 20;
   localparam logic [15:0] VSSA_H_MAX = 16'h7fff;
   localparam logic [15:0] VSSA_H_MIN = 16'h8000;
   localparam logic [31:0] VSSA_W_MAX = 32'h7fffffff;
   localparam logic [31:0] VSSA_W_MIN = 32'h80000000;
   localparam logic [31:0] VSSA_ZERO = 32'h00000000;
endpackage
`default_nettype wire

/* File: core/vssa_q15_lane.sv */
// Purpose: one Q15 halfword subtract lane, wrapping or saturating
// Assumes: operands are signed Q15
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module vssa_q15_lane
   import vssa_pkg::*;
(
   // operands
   input wire logic [15:0] a,
   input wire logic [15:0] b,
   input wire logic sat,
   // result
   output logic [15:0] result,
   output logic ovf
);
   // ==========================================================
   // lane arithmetic
   logic [16:0] diff;
   // sign-extend to 17 bits so overflow shows in the top two bits
   always_comb begin
      diff = {a[15], a} - {b[15], b};
      ovf = diff[16] ^ diff[15];
      result = diff[15:0];
      if (sat && ovf) begin
         result = diff[16] ? VSSA_H_MIN : VSSA_H_MAX;
      end
   end
endmodule
`default_nettype wire

/* File: verification/vssa_host_model.sv */
// Purpose: pipeline side model holding the dsp control register
// Assumes: unit presents flag requests as a one-cycle mask pulse
// Notes: only the overflow bit is modelled
`timescale 1ns/100ps
`default_nettype none
module vssa_host_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // flag request from the unit
   input wire logic [31:0] flag_set_mask,
   // control register as software would read it
   output logic [31:0] ctrl_reg
);
   // ==========================================================
   // sticky merge: host only ever ors requests in, never clears
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= 32'h00000000;
      end else begin
         ctrl_reg <= ctrl_reg | flag_set_mask;
      end
   end
endmodule
`default_nettype wire

/* File: verification/vector_shift_subtract_alu_tb.sv */
// Purpose: self-checking bench for the shift/subtract execute unit
// Assumes: answer one cycle after the issuing edge
// Notes: operands always well formed packed values
`timescale 1ns/100ps
`default_nettype none
module vector_shift_subtract_alu_tb
   import vssa_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, dsp_enabled = 1'b0;
   vssa_op_type op = VSSA_OP_NONE;
   logic [2:0] shift_amount = 3'h0;
   logic [31:0] first_source_reg = 32'h0, second_source_reg = 32'h0;
   logic result_valid, flag_set, dsp_disabled_exc, reserved_instr_exc;
   logic [31:0] result, flag_set_mask, ctrl_reg;
   int errors = 0, samples_checked = 0, cycles = 0;
   // ==========================================================
   // clock, timeout and instances
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         close_out();
      end
   end
   vssa_alu dut (.clk_sys(clk_sys), .rst_n(rst_n), .issue_valid(issue_valid), .op(op),
      .dsp_enabled(dsp_enabled), .shift_amount(shift_amount),
      .first_source_reg(first_source_reg), .second_source_reg(second_source_reg),
      .result_valid(result_valid), .result(result), .flag_set(flag_set),
      .flag_set_mask(flag_set_mask), .dsp_disabled_exc(dsp_disabled_exc),
      .reserved_instr_exc(reserved_instr_exc));
   vssa_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .flag_set_mask(flag_set_mask),
      .ctrl_reg(ctrl_reg));
   // ==========================================================
   // reference: {flag, result}, built lane by lane from the rules
   function automatic logic [32:0] ref_op(vssa_op_type o, logic [2:0] s, logic [31:0] a,
      logic [31:0] b);
      logic [16:0] d;
      logic [32:0] w;
      logic [31:0] r;
      logic f;
      f = 1'b0;
      r = 32'h0;
      for (int i = 0; i < 4; i++) begin
         if (o == VSSA_OP_QB_SHR_IMM) r[i*8+:8] = b[i*8+:8] >> s;
         if (o == VSSA_OP_QB_SHR_VAR) r[i*8+:8] = b[i*8+:8] >> a[2:0];
      end
      for (int i = 0; i < 2; i++) begin
         d = {a[i*16+15], a[i*16+:16]} - {b[i*16+15], b[i*16+:16]};
         if (o == VSSA_OP_PH_SHR_VAR) r[i*16+:16] = b[i*16+:16] >> a[3:0];
         if (o == VSSA_OP_PH_SUB_WRAP || o == VSSA_OP_PH_SUB_SAT) begin
            r[i*16+:16] = d[15:0];
            if (d[16] != d[15]) f = 1'b1;
            if (d[16] != d[15] && o == VSSA_OP_PH_SUB_SAT) begin
               r[i*16+:16] = d[16] ? VSSA_H_MIN : VSSA_H_MAX;
            end
         end
      end
      w = {a[31], a} - {b[31], b};
      if (o == VSSA_OP_W_SUB_SAT) begin
         f = w[32] != w[31];
         r = !f ? w[31:0] : (w[32] ? VSSA_W_MIN : VSSA_W_MAX);
      end
      return {f, r};
   endfunction
   // ==========================================================
   // compare and issue helpers
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic run(input vssa_op_type o, input logic [2:0] s, input logic [31:0] a,
      input logic [31:0] b, input logic en);
      logic [32:0] e;
      logic rsv;
      @(posedge clk_sys);
      issue_valid <= 1'b1;
      op <= o;
      shift_amount <= s;
      first_source_reg <= a;
      second_source_reg <= b;
      dsp_enabled <= en;
      @(posedge clk_sys);
      issue_valid <= 1'b0;
      #1;
      rsv = (o == VSSA_OP_NONE) || (o == vssa_op_type'(3'h4));
      e = (en && !rsv) ? ref_op(o, s, a, b) : 33'h0;
      chk_bit("result_valid", en && !rsv, result_valid);
      chk("result", e[31:0], result);
      chk_bit("flag_set", e[32], flag_set);
      chk("flag_set_mask", {11'h0, e[32], 20'h0}, flag_set_mask);
      chk_bit("disabled_exc", !en, dsp_disabled_exc);
      chk_bit("reserved_exc", en && rsv, reserved_instr_exc);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_shifts();
      for (int c = 0; c < 16; c++) begin
         run(VSSA_OP_QB_SHR_IMM, c[2:0], 32'h5, 32'h80ff7f01, 1'b1);
         run(VSSA_OP_PH_SHR_VAR, 3'h0, 32'hfffffff0 | c, 32'h8001ffff, 1'b1);
         run(VSSA_OP_QB_SHR_VAR, 3'h0, 32'hfffffff8 | c, 32'hf0817f01, 1'b1);
      end
   endtask
   task automatic t_subs();
      logic [31:0] ta[4] = '{32'h80000000, 32'h7fff8000, 32'h12345678, 32'h80007fff};
      logic [31:0] tb[4] = '{32'h00010000, 32'hffff0001, 32'h01020304, 32'h7fff8000};
      vssa_op_type so[3] = '{VSSA_OP_PH_SUB_WRAP, VSSA_OP_PH_SUB_SAT, VSSA_OP_W_SUB_SAT};
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 3; k++) begin
            run(so[k], 3'h0, ta[i], tb[i], 1'b1);
         end
      end
   endtask
   task automatic t_refuse();
      run(VSSA_OP_PH_SUB_SAT, 3'h0, 32'h80000000, 32'h00010000, 1'b0);
      run(VSSA_OP_NONE, 3'h0, 32'h80000000, 32'h00010000, 1'b1);
      run(vssa_op_type'(3'h4), 3'h0, 32'h1, 32'h2, 1'b1);
   endtask
   task automatic t_flag();
      run(VSSA_OP_QB_SHR_IMM, 3'h3, 32'h0, 32'hffffffff, 1'b1);
      run(VSSA_OP_W_SUB_SAT, 3'h0, 32'h1, 32'h2, 1'b1);
      @(posedge clk_sys);
      #1 chk("ctrl_reg", 32'h0, ctrl_reg);
      run(VSSA_OP_PH_SUB_WRAP, 3'h0, 32'h80000000, 32'h00010000, 1'b1);
      run(VSSA_OP_PH_SUB_SAT, 3'h0, 32'h3, 32'h1, 1'b1);
      @(posedge clk_sys);
      #1 chk("ctrl_reg", 32'h00100000, ctrl_reg);
   endtask
   task automatic close_out();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_flag();
      t_shifts();
      t_subs();
      t_refuse();
      close_out();
   end
endmodule
`default_nettype wire
